// ===== inc/cihc_pkg.sv
// Purpose: shared constants for the interrupt and halt control block
// Assumes: apb byte addresses, one aligned 32-bit word per register
// Notes:   flag layout follows the processor's condition flag byte
package cihc_pkg;
	// apb register byte offsets
	localparam logic [7:0] OFS_PC     = 8'h00;   // program counter
	localparam logic [7:0] OFS_SP     = 8'h04;   // stack pointer
	localparam logic [7:0] OFS_IX     = 8'h08;   // index register
	localparam logic [7:0] OFS_ACC    = 8'h0C;   // a in [7:0], b in [15:8]
	localparam logic [7:0] OFS_FLAG   = 8'h10;   // flag_register
	localparam logic [7:0] OFS_STATUS = 8'h14;   // read only state
	// flag_register bit positions
	localparam int FLG_C = 0;                    // carry out of bit 7
	localparam int FLG_V = 1;                    // overflow
	localparam int FLG_Z = 2;                    // zero
	localparam int FLG_N = 3;                    // negative
	localparam int FLG_I = 4;                    // interrupt mask
	localparam int FLG_H = 5;                    // half carry out of bit 3
	localparam logic [7:0] FLAG_ONES  = 8'hC0;   // bits 6 and 7 read as one
	localparam logic [7:0] FLAG_RESET = 8'hD0;   // mask set out of reset
	// vectors and reset values
	localparam logic [15:0] VEC_NMI   = 16'hFFFC;
	localparam logic [15:0] VEC_IRQ   = 16'hFFF8;
	localparam logic [15:0] PC_RESET  = 16'h0000;
	localparam logic [15:0] SP_RESET  = 16'h00FF;
	localparam logic [15:0] IX_RESET  = 16'h0000;
	// internal ram window and stacking length
	localparam int          RAM_WORDS  = 128;
	localparam logic [15:0] RAM_LIMIT  = 16'h0080;
	localparam logic [2:0]  PUSH_LAST  = 3'd6;   // seven bytes stacked
	// opcodes that drive the alu, all others behave as no-operation
	localparam logic [7:0] OP_ADD_BA  = 8'h1B;   // a = a + b
	localparam logic [7:0] OP_SUB_BA  = 8'h10;   // a = a - b
	typedef enum {ST_FETCH, ST_PUSH, ST_VEC_HI, ST_VEC_LO, ST_HALT} cihc_state_t;
endpackage

// ===== core/cihc_top.sv
// Purpose: programmer registers, interrupt and halt sequencing, on-chip ram
// Assumes: single-cycle memory, read data valid in the cycle the address shows
// Notes:   registers are also reachable over apb, which always answers at once
//
// How it works
// - 16-bit program counter tracks current instruction
// - two-byte stack pointer addresses next free slot
// - 16-bit index register for data or base
// - two 8-bit accumulators feed the alu
// - alu updates n, z, v, c flags, and h on add only
// - interrupt mask lives in flag bit 4
// - flag bits 6 and 7 read one
// - falling nmi edge requests sequence, mask ignored
// - interrupts recognised only at instruction end
// - stack pc, index, accumulators and flags
// - nmi vector fetched from fffc and fffd
// - low irq level starts sequence if unmasked
// - accepting irq sets the interrupt mask
// - irq vector fetched from fff8 and fff9
// - service only while halt high, else pend
// - halt low stops, shows next address, bus free
// - 128 by 8-bit internal ram present
// - ram enable low blocks internal ram access
// - internal ram decodes lowest 128 addresses
//
// Design decisions made here: the APB slave port and the register addresses.
`timescale 1ns/10ps
module cihc_top #(
	parameter logic [15:0] P_PC_RESET = cihc_pkg::PC_RESET,  // start address
	parameter logic [15:0] P_SP_RESET = cihc_pkg::SP_RESET   // initial stack top
) (
	input  wire logic        i_sys_clk,          // 250 MHz system clock
	input  wire logic        i_srst,             // synchronous reset, high
	input  wire logic        i_nmi_n,            // non-maskable request pin
	input  wire logic        i_irq_n,            // maskable request pin
	input  wire logic        i_halt_n,           // halt pin, low stops
	input  wire logic        i_internal_ram_en,  // ram enable pin
	input  wire logic [7:0]  i_mem_rdata,        // external read data
	output logic      [15:0] o_addr,             // address bus
	output logic      [7:0]  o_wdata,            // write data
	output logic             o_rd_wr_n,          // high read, low write
	output logic             o_mem_cycle_valid,  // memory cycle in progress
	output logic             o_bus_avail,        // bus released in halt
	output logic             o_ram_sel,          // cycle served on chip
	input  wire logic        i_psel,             // apb select
	input  wire logic        i_penable,          // apb access phase
	input  wire logic        i_pwrite,           // apb direction
	input  wire logic [7:0]  i_paddr,            // apb byte address
	input  wire logic [31:0] i_pwdata,           // apb write data
	output logic      [31:0] o_prdata,           // apb read data
	output logic             o_pready,           // apb ready
	output logic             o_pslverr           // apb error
);
	import cihc_pkg::*;

	// pin synchronisers, stage one is only read by stage two
	logic [3:0]  sync1_ff;                        // nmi, irq, halt, ram en
	logic [3:0]  sync2_ff;                        // usable levels
	logic        nmi_prev_ff;                     // for edge detection
	logic        nmi_pend_ff;                     // latched nmi request
	// programmer visible registers
	logic [15:0] pc_ff;
	logic [15:0] sp_ff;
	logic [15:0] ix_ff;
	logic [7:0]  acc_a_ff;
	logic [7:0]  acc_b_ff;
	logic [7:0]  flag_ff;
	// sequencer
	cihc_state_t state_ff;
	cihc_state_t nxt_state;
	logic [2:0]  push_cnt_ff;                     // byte being stacked
	logic [7:0]  vec_hi_ff;                       // vector high byte
	logic        vec_nmi_ff;                      // which vector to fetch
	logic [15:0] addr_ff;
	logic [7:0]  wdata_ff;
	logic        rw_ff;
	logic        vma_ff;
	logic        ba_ff;
	logic [7:0]  ram [RAM_WORDS];                 // on-chip ram array
	// combinational helpers
	logic        nmi_s;
	logic        irq_s;
	logic        halt_s;
	logic        ram_en_s;
	logic        ram_hit;
	logic [7:0]  rd_byte;
	logic        at_bound;
	logic        take_nmi;
	logic        take_irq;
	logic [15:0] pc_next;
	logic [8:0]  alu_res;                         // {carry, result}
	logic        alu_h;
	logic        alu_v;
	logic        is_alu;
	logic        apb_wr;
	logic        ofs_ok;

	// alu: add or subtract b from a, carry is borrow on subtract
	function automatic logic [10:0] alu_op(input logic [7:0] a,
		input logic [7:0] b, input logic sub);
		logic [8:0] r;
		logic       h;
		logic       v;
		r = '0;
		h = 1'b0;
		v = 1'b0;
		if (sub) begin
			r = {1'b0, a} - {1'b0, b};
			v = (a[7] ^ b[7]) & (a[7] ^ r[7]);
		end else begin
			r = {1'b0, a} + {1'b0, b};
			h = (a[3] & b[3]) | (b[3] & ~r[3]) | (~r[3] & a[3]);
			v = ~(a[7] ^ b[7]) & (a[7] ^ r[7]);
		end
		return {v, h, r};
	endfunction

	// stacking order: pc low, pc high, index low/high, a, b, flags
	function automatic logic [7:0] push_byte(input logic [2:0] n,
		input logic [15:0] pc, input logic [15:0] ix, input logic [7:0] a,
		input logic [7:0] b, input logic [7:0] f);
		case (n)
			3'd0:    return pc[7:0];
			3'd1:    return pc[15:8];
			3'd2:    return ix[7:0];
			3'd3:    return ix[15:8];
			3'd4:    return a;
			3'd5:    return b;
			default: return f | FLAG_ONES;
		endcase
	endfunction

	// two flops on each nmi, irq, halt and ram enable pin before any logic looks at it
	// reset loads idle levels (ram enable low): no false nmi edge, no early ram hit
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			sync1_ff <= 4'hE;
			sync2_ff <= 4'hE;
		end else begin
			sync1_ff <= {i_nmi_n, i_irq_n, i_halt_n, i_internal_ram_en};
			sync2_ff <= sync1_ff;
		end
	end
	assign nmi_s    = sync2_ff[3];
	assign irq_s    = sync2_ff[2];
	assign halt_s   = sync2_ff[1];
	assign ram_en_s = sync2_ff[0];

	// address decode: low window goes on chip only while enabled
	assign ram_hit  = (addr_ff < RAM_LIMIT) && ram_en_s;
	assign rd_byte  = ram_hit ? ram[addr_ff[6:0]] : i_mem_rdata;

	// boundary decisions, taken at the end of each opcode fetch
	assign at_bound = (state_ff == ST_FETCH);
	assign take_nmi = at_bound && halt_s && nmi_pend_ff;
	assign take_irq = at_bound && halt_s && !nmi_pend_ff
		&& !irq_s && !flag_ff[FLG_I];
	assign pc_next  = pc_ff + 16'h0001;

	// alu result for the opcode on the bus
	assign is_alu   = at_bound && ((rd_byte == OP_ADD_BA) || (rd_byte == OP_SUB_BA));
	assign {alu_v, alu_h, alu_res} = alu_op(acc_a_ff, acc_b_ff, rd_byte == OP_SUB_BA);

	// nmi edge catcher; a new edge wins over the clear of the old one
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			nmi_prev_ff <= 1'b1;
			nmi_pend_ff <= 1'b0;
		end else begin
			nmi_prev_ff <= nmi_s;
			if (nmi_prev_ff && !nmi_s) begin
				nmi_pend_ff <= 1'b1;
			end else if (take_nmi) begin
				nmi_pend_ff <= 1'b0;
			end
		end
	end

	// sequencer state
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_FETCH: begin
				if (!halt_s) begin
					nxt_state = ST_HALT;
				end else if (take_nmi || take_irq) begin
					nxt_state = ST_PUSH;
				end
			end
			ST_PUSH: begin
				if (push_cnt_ff == PUSH_LAST) begin
					nxt_state = ST_VEC_HI;
				end
			end
			ST_VEC_HI: nxt_state = ST_VEC_LO;
			ST_VEC_LO: nxt_state = ST_FETCH;
			ST_HALT: begin
				if (halt_s) begin
					nxt_state = ST_FETCH;
				end
			end
			default:   nxt_state = ST_FETCH;
		endcase
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			state_ff <= ST_FETCH;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// stacking counter and vector choice
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			push_cnt_ff <= 3'd0;
			vec_nmi_ff  <= 1'b0;
			vec_hi_ff   <= 8'h00;
		end else begin
			if (state_ff == ST_PUSH) begin
				push_cnt_ff <= push_cnt_ff + 3'd1;
			end else begin
				push_cnt_ff <= 3'd0;
			end
			if (take_nmi || take_irq) begin
				vec_nmi_ff <= take_nmi;
			end
			if (state_ff == ST_VEC_HI) begin
				vec_hi_ff <= rd_byte;
			end
		end
	end

	// bus outputs for the next cycle; halt shows next address, no cycle
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			addr_ff  <= P_PC_RESET;
			wdata_ff <= 8'h00;
			rw_ff    <= 1'b1;
			vma_ff   <= 1'b1;
			ba_ff    <= 1'b0;
		end else begin
			rw_ff    <= 1'b1;
			vma_ff   <= 1'b1;
			ba_ff    <= 1'b0;
			case (nxt_state)
				ST_FETCH: begin
					if (state_ff == ST_VEC_LO) begin
						addr_ff <= {vec_hi_ff, rd_byte};
					end else if (state_ff == ST_HALT) begin
						addr_ff <= pc_ff;
					end else begin
						addr_ff <= pc_next;
					end
				end
				ST_PUSH: begin
					addr_ff  <= (state_ff == ST_PUSH) ? sp_ff - 16'h0001 : sp_ff;
					wdata_ff <= push_byte((state_ff == ST_PUSH) ? push_cnt_ff + 3'd1 : 3'd0,
						(state_ff == ST_PUSH) ? pc_ff : pc_next,
						ix_ff, acc_a_ff, acc_b_ff, flag_ff);
					rw_ff    <= 1'b0;
				end
				ST_VEC_HI: begin
					addr_ff <= take_nmi || (state_ff != ST_FETCH && vec_nmi_ff)
						? VEC_NMI : VEC_IRQ;
				end
				ST_VEC_LO: addr_ff <= addr_ff | 16'h0001;
				ST_HALT: begin
					addr_ff <= (state_ff == ST_FETCH) ? pc_next : pc_ff;
					vma_ff  <= 1'b0;
					ba_ff   <= 1'b1;
				end
				default: addr_ff <= pc_ff;
			endcase
		end
	end

	// on-chip ram write, blocked unless enabled and decoded
	always_ff @(posedge i_sys_clk) begin
		if (vma_ff && !rw_ff && ram_hit) begin
			ram[addr_ff[6:0]] <= wdata_ff;
		end
	end

	// apb strobes; every access answers in its first access cycle
	assign apb_wr = i_psel && i_penable && i_pwrite;
	assign ofs_ok = (i_paddr[1:0] == 2'b00) && (i_paddr <= OFS_STATUS);

	// program counter: fetch advances, vector loads, software may write
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			pc_ff <= P_PC_RESET;
		end else if (at_bound) begin
			// the fetched instruction completes even when halt stops after it
			pc_ff <= pc_next;
		end else if (state_ff == ST_VEC_LO) begin
			pc_ff <= {vec_hi_ff, rd_byte};
		end else if (apb_wr && i_paddr == OFS_PC) begin
			pc_ff <= i_pwdata[15:0];
		end
	end

	// stack pointer: decrements once per stacked byte
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			sp_ff <= P_SP_RESET;
		end else if (state_ff == ST_PUSH) begin
			sp_ff <= sp_ff - 16'h0001;
		end else if (apb_wr && i_paddr == OFS_SP) begin
			sp_ff <= i_pwdata[15:0];
		end
	end

	// index register, software data or base for indexed access
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			ix_ff <= IX_RESET;
		end else if (apb_wr && i_paddr == OFS_IX) begin
			ix_ff <= i_pwdata[15:0];
		end
	end

	// accumulators; the alu result lands in a
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			acc_a_ff <= 8'h00;
			acc_b_ff <= 8'h00;
		end else if (is_alu) begin
			acc_a_ff <= alu_res[7:0];
		end else if (apb_wr && i_paddr == OFS_ACC) begin
			acc_a_ff <= i_pwdata[7:0];
			acc_b_ff <= i_pwdata[15:8];
		end
	end

	// flags: alu updates, irq acceptance masks, software may rewrite
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			flag_ff <= FLAG_RESET;
		end else begin
			if (is_alu) begin
				flag_ff[FLG_N] <= alu_res[7];
				flag_ff[FLG_Z] <= (alu_res[7:0] == 8'h00);
				flag_ff[FLG_V] <= alu_v;
				flag_ff[FLG_C] <= alu_res[8];
				if (rd_byte == OP_ADD_BA) begin
					flag_ff[FLG_H] <= alu_h;
				end
			end else if (apb_wr && i_paddr == OFS_FLAG) begin
				flag_ff <= i_pwdata[7:0] | FLAG_ONES;
			end
			// mask set last so it beats both the alu and a software write
			if (take_irq) begin
				flag_ff[FLG_I] <= 1'b1;
			end
		end
	end

	// apb read mux; unmapped or misaligned addresses error out
	always_comb begin
		o_prdata = 32'h0000_0000;
		case (i_paddr)
			OFS_PC:     o_prdata = {16'h0000, pc_ff};
			OFS_SP:     o_prdata = {16'h0000, sp_ff};
			OFS_IX:     o_prdata = {16'h0000, ix_ff};
			OFS_ACC:    o_prdata = {16'h0000, acc_b_ff, acc_a_ff};
			OFS_FLAG:   o_prdata = {24'h00_0000, flag_ff | FLAG_ONES};
			OFS_STATUS: o_prdata = {28'h000_0000, ba_ff, !irq_s, nmi_pend_ff,
				ram_en_s};
			default:    o_prdata = 32'h0000_0000;
		endcase
	end
	assign o_pready  = 1'b1;
	assign o_pslverr = i_psel && i_penable && !ofs_ok;

	// bus pins come straight from flops, except ram select, which ands the ram decode with the valid flop
	assign o_addr            = addr_ff;
	assign o_wdata           = wdata_ff;
	assign o_rd_wr_n         = rw_ff;
	assign o_mem_cycle_valid = vma_ff;
	assign o_bus_avail       = ba_ff;
	assign o_ram_sel         = ram_hit && vma_ff;
endmodule

// ===== bench/cihc_mem_model.sv
// Purpose: external memory partner with zero wait states
// Assumes: read data follows the address in the same cycle
// Notes:   an idle bus shows the inverted last byte, never stale data
`timescale 1ns/10ps
module cihc_mem_model (
	input  wire logic        i_sys_clk,   // system clock
	input  wire logic [15:0] i_addr,      // address bus
	input  wire logic [7:0]  i_wdata,     // write data
	input  wire logic        i_rd_wr_n,   // high read, low write
	input  wire logic        i_vma,       // memory cycle valid
	input  wire logic        i_ram_sel,   // cycle served on chip
	output logic      [7:0]  o_rdata      // read data
);
	logic [7:0] mem [0:65535];       // whole external space, filled by the bench
	logic [7:0] last_ff = 8'h00;     // last byte put on the bus
	// without a valid cycle the lines float, so show something that is wrong
	assign o_rdata = i_vma ? mem[i_addr] : ~last_ff;
	// writes land at the end of the cycle; on-chip cycles leave this space alone
	always @(posedge i_sys_clk) begin
		if (i_vma)
			last_ff <= mem[i_addr];
		if (i_vma && !i_rd_wr_n && !i_ram_sel)
			mem[i_addr] <= i_wdata;
	end
endmodule

// ===== bench/cihc_props.sv
// Purpose: port checks of stacking, vectors, halt and on-chip ram decode
// Assumes: one clock domain, only top-level ports visible
// Notes:   ram enable passes a synchroniser, so its check allows slack
`timescale 1ns/10ps
module cihc_props import cihc_pkg::*; (
	input wire logic        i_sys_clk,          // system clock
	input wire logic        i_srst,             // synchronous reset
	input wire logic        i_internal_ram_en,  // ram enable pin
	input wire logic [7:0]  i_mem_rdata,        // external read data
	input wire logic [15:0] o_addr,             // address bus
	input wire logic        o_rd_wr_n,          // direction
	input wire logic        o_mem_cycle_valid,  // valid cycle
	input wire logic        o_bus_avail,        // halted
	input wire logic        o_ram_sel,          // on-chip cycle
	input wire logic        i_psel,             // apb select
	input wire logic        i_pwrite,           // apb direction
	input wire logic [7:0]  i_paddr,            // apb address
	input wire logic [31:0] o_prdata            // apb read data
);
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_srst);
	logic wr_c;  // valid write cycle
	logic rd_c;  // valid read cycle
	assign wr_c = o_mem_cycle_valid && !o_rd_wr_n;
	assign rd_c = o_mem_cycle_valid && o_rd_wr_n;
	// seven stacked bytes, then the first vector byte
	sequence s_push_run;
		wr_c [*7];
	endsequence
	sequence s_vec_hi;
		rd_c && (o_addr == VEC_NMI || o_addr == VEC_IRQ);
	endsequence
	sequence s_vec_lo;
		rd_c && (o_addr == 16'hFFFD || o_addr == 16'hFFF9);
	endsequence
	chk_push_run: assert property (
		wr_c && !$past(wr_c) |-> s_push_run ##1 s_vec_hi) else $error("stacking run broken");
	chk_push_down: assert property (
		wr_c && $past(wr_c) |-> o_addr == $past(o_addr) - 16'h0001) else $error("stack not down");
	chk_nmi_pair: assert property (
		rd_c && o_addr == VEC_NMI |=> rd_c && o_addr == 16'hFFFD) else $error("nmi vector pair");
	chk_irq_pair: assert property (
		rd_c && o_addr == VEC_IRQ |=> rd_c && o_addr == 16'hFFF9) else $error("irq vector pair");
	chk_vec_jump: assert property (
		s_vec_lo |=> rd_c && o_addr == {$past(i_mem_rdata, 2), $past(i_mem_rdata)})
		else $error("vector target wrong");
	chk_halt_quiet: assert property (
		o_bus_avail |-> !o_mem_cycle_valid) else $error("cycle while halted");
	chk_halt_hold: assert property (
		o_bus_avail && $past(o_bus_avail) |-> $stable(o_addr)) else $error("halt address moved");
	chk_ram_map: assert property (
		o_ram_sel |-> o_mem_cycle_valid && o_addr < RAM_LIMIT) else $error("ram decode wrong");
	chk_ram_block: assert property (
		!i_internal_ram_en [*4] |-> !o_ram_sel) else $error("ram used while disabled");
	chk_flag_ones: assert property (
		i_psel && !i_pwrite && i_paddr == OFS_FLAG |-> o_prdata[7:6] == 2'b11)
		else $error("flag top bits not one");
endmodule
bind cihc_top cihc_props u_props (.i_sys_clk(i_sys_clk), .i_srst(i_srst),
	.i_internal_ram_en(i_internal_ram_en), .i_mem_rdata(i_mem_rdata), .o_addr(o_addr),
	.o_rd_wr_n(o_rd_wr_n), .o_mem_cycle_valid(o_mem_cycle_valid), .o_bus_avail(o_bus_avail),
	.o_ram_sel(o_ram_sel), .i_psel(i_psel), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
	.o_prdata(o_prdata));

// ===== bench/cpu_interrupt_halt_control_tb.sv
// Purpose: self-checking bench for interrupt and halt control
// Assumes: zero wait state memory, apb answers at once
// Notes:   internal ram is off except while the irq stacks on chip
`timescale 1ns/10ps
`define CHECK(nm, ex, gt) begin n_tests++; if ((gt) !== (ex)) begin n_mismatch++; \
	$display("mismatch %s expected %h seen %h", nm, ex, gt); end end
module cpu_interrupt_halt_control_tb;
	import cihc_pkg::*;
	logic        clk = 0, srst = 1, nmi_n = 1, irq_n = 1, halt_n = 1, ram_en = 0;
	logic        psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
	logic        rw, mem_cycle_valid, ba, rsel, saw_rsel = 0;  // bus outputs and on-chip marker
	logic [7:0]  paddr = 8'h00, rdata, wdata;
	logic [15:0] addr, hold, stk;                 // hold: address shown in halt
	logic [31:0] pwdata = 32'h0000_0000, prdata, q;
	logic [7:0]  exp_stk [7];                     // expected stacked bytes
	int          n_mismatch = 0, n_tests = 0, n_nmi = 0, n_irq = 0;
	cihc_top u_dut (.i_sys_clk(clk), .i_srst(srst), .i_nmi_n(nmi_n), .i_irq_n(irq_n),
		.i_halt_n(halt_n), .i_internal_ram_en(ram_en), .i_mem_rdata(rdata), .o_addr(addr),
		.o_wdata(wdata), .o_rd_wr_n(rw), .o_mem_cycle_valid(mem_cycle_valid), .o_bus_avail(ba),
		.o_ram_sel(rsel), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
		.i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
		.o_pslverr(pslverr));
	cihc_mem_model u_mem (.i_sys_clk(clk), .i_addr(addr), .i_wdata(wdata), .i_rd_wr_n(rw),
		.i_vma(mem_cycle_valid), .i_ram_sel(rsel), .o_rdata(rdata));
	// 250 MHz clock
	initial begin
		forever #2 clk = ~clk;
	end
	// count vector fetches; a second one per request means a lost latch clear
	always @(posedge clk) begin
		if (mem_cycle_valid === 1'b1 && addr === VEC_NMI)
			n_nmi++;
		if (mem_cycle_valid === 1'b1 && addr === VEC_IRQ)
			n_irq++;
		if (rsel === 1'b1)
			saw_rsel = 1'b1;
	end
	// one apb transfer; read data and error taken at the ready edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	// wait for a valid cycle at an address; the watchdog bounds it
	task automatic wait_addr(input logic [15:0] a);
		do @(posedge clk); while (!(mem_cycle_valid === 1'b1 && addr === a));
	endtask
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// a hang counts as a failure
	initial begin
		#20000;
		n_mismatch++;
		complete_run;
	end
	initial begin
		// no-operation everywhere, two vectors
		for (int i = 0; i < 65536; i++) u_mem.mem[i] = 8'h01;
		u_mem.mem[16'hFFFC] = 8'h12;
		u_mem.mem[16'hFFFD] = 8'h34;
		u_mem.mem[16'hFFF8] = 8'h56;
		u_mem.mem[16'hFFF9] = 8'h78;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		// reset values; ram enable held low like the ram-less variant
		apb(1'b0, OFS_SP, 32'h0000_0000);
		`CHECK("sp", SP_RESET, q[15:0])
		apb(1'b0, OFS_FLAG, 32'h0000_0000);
		`CHECK("flags", FLAG_RESET, q[7:0])
		apb(1'b0, OFS_IX, 32'h0000_0000);
		`CHECK("ix", 16'h0000, q[15:0])
		apb(1'b0, 8'h18, 32'h0000_0000);
		`CHECK("unmapped", 1'b1, err)
		`CHECK("no ram use", 1'b0, saw_rsel)
		// halt, then load registers while stopped
		halt_n <= 1'b0;
		repeat (8) @(posedge clk);
		`CHECK("bus_avail", 1'b1, ba)
		`CHECK("vma", 1'b0, mem_cycle_valid)
		hold = addr;
		apb(1'b0, OFS_PC, 32'h0000_0000);
		`CHECK("pc", hold, q[15:0])
		apb(1'b1, OFS_IX, 32'h0000_BEEF);
		apb(1'b1, OFS_ACC, 32'h0000_0808);
		apb(1'b1, OFS_FLAG, 32'h0000_0000);
		apb(1'b0, OFS_FLAG, 32'h0000_0000);
		`CHECK("flag ones", 8'hC0, q[7:0])
		// single step one add with half carry
		u_mem.mem[hold] = OP_ADD_BA;
		halt_n <= 1'b1;
		@(posedge clk);
		halt_n <= 1'b0;
		repeat (8) @(posedge clk);
		`CHECK("step addr", hold + 16'h0001, addr)
		apb(1'b0, OFS_ACC, 32'h0000_0000);
		`CHECK("acc", 16'h0810, q[15:0])
		apb(1'b0, OFS_FLAG, 32'h0000_0000);
		`CHECK("alu flags", 8'hE0, q[7:0])
		// nmi edge while halted and masked: pends, then stacks externally
		apb(1'b1, OFS_FLAG, 32'h0000_00D0);
		apb(1'b1, OFS_SP, 32'h0000_0200);
		nmi_n <= 1'b0;
		repeat (3) @(posedge clk);
		nmi_n <= 1'b1;
		repeat (4) @(posedge clk);
		apb(1'b0, OFS_STATUS, 32'h0000_0000);
		`CHECK("nmi pending", 1'b1, q[1])
		`CHECK("nmi in halt", 0, n_nmi)
		stk = hold + 16'h0002;
		exp_stk = '{stk[7:0], stk[15:8], 8'hEF, 8'hBE, 8'h10, 8'h08, 8'hD0};
		halt_n <= 1'b1;
		wait_addr(16'h1234);
		`CHECK("nmi taken", 1, n_nmi)
		for (int i = 0; i < 7; i++) `CHECK("stack", exp_stk[i], u_mem.mem[16'h0200 - i])
		apb(1'b0, OFS_SP, 32'h0000_0000);
		`CHECK("sp after", 16'h01F9, q[15:0])
		// irq held low: ignored while masked, taken once unmasked, stacks on chip
		irq_n <= 1'b0;
		ram_en <= 1'b1;
		repeat (20) @(posedge clk);
		`CHECK("masked irq", 0, n_irq)
		apb(1'b1, OFS_SP, 32'h0000_0060);
		apb(1'b1, OFS_FLAG, 32'h0000_00C0);
		wait_addr(16'h5678);
		`CHECK("irq taken", 1, n_irq)
		irq_n <= 1'b1;
		apb(1'b0, OFS_FLAG, 32'h0000_0000);
		`CHECK("mask set", 1'b1, q[FLG_I])
		`CHECK("ram served", 1'b1, saw_rsel)
		`CHECK("ext untouched", 8'h01, u_mem.mem[16'h0060])
		ram_en <= 1'b0;
		repeat (20) @(posedge clk);
		apb(1'b0, OFS_STATUS, 32'h0000_0000);
		`CHECK("ram off", 1'b0, q[0])
		`CHECK("one nmi", 1, n_nmi)
		`CHECK("one irq", 1, n_irq)
		complete_run;
	end
endmodule
